// *** verilog/lfs_pkg.sv ***
// Constants, register map and types of the elastic bank input FIFO block.
// Functional notes
// - Each bank written on own clock; FIFOs absorb skew
// - Write side latches data on bank clock
// - One arrival delay readback per bank
// - Readbacks of staggered banks differ by one
// - Delay range 32, 16 or 8 by mode
// - Strobe alignment gives non-deterministic latency
// - Sticky flow alarms, only on toggling data
// - Some delay settings unusable near arrival point
// - Delay shifts oscillator sync modulo 8/16
// - Two capture flops and a re-read detect slow drift
// - Alignment pulse aligns read side, strobe write
// - Alignment pulse captured in one cycle
// - Strobe resets bank write pointer
// - Strobe reference is bank 0, else 2
package lfs_pkg;
  localparam int          NBANK           = 4;
  localparam int          WORD_W          = 12;
  localparam int          DEPTH           = 32;
  localparam int          PTR_W           = 5;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_DELAY       = 8'h04;
  localparam logic [7:0]  OFF_READBACK    = 8'h08;
  localparam logic [7:0]  OFF_ALARM       = 8'h0c;
  localparam logic [7:0]  OFF_STATUS      = 8'h10;
  // Control fields
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_DRO_BIT    = 2;
  localparam int          CTRL_ALIGN_BIT  = 3;
  localparam int          CTRL_SREN_BIT   = 4;
  localparam int          CTRL_BANK_LSB   = 8;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0f12;
  localparam logic [4:0]  DELAY_RESET     = 5'h00;
  // Alarm and readback fields
  localparam int          ALM_UNDER_LSB   = 0;
  localparam int          ALM_OVER_LSB    = 4;
  localparam int          RB_STRIDE       = 8;
  // Bank modes and range masks
  localparam logic [1:0]  LVDS_MODE_ONE   = 2'h0;
  localparam logic [1:0]  LVDS_MODE_TWO   = 2'h1;
  localparam logic [1:0]  LVDS_MODE_FOUR  = 2'h2;
  localparam logic [4:0]  MASK_32         = 5'h1f;
  localparam logic [4:0]  MASK_16         = 5'h0f;
  localparam logic [4:0]  MASK_8          = 5'h07;
  localparam logic [4:0]  OSC_MOD8        = 5'h07;
  localparam logic [4:0]  OSC_MOD16       = 5'h0f;
  // Read side alignment state
  typedef enum logic [1:0] {
    LFS_ALIGN_IDLE = 2'b00,
    LFS_ALIGN_WAIT = 2'b01,
    LFS_ALIGN_RUN  = 2'b11
  } lfs_align_t;
endpackage

// *** verilog/lfs_fifo_sync.sv ***
// Bank input FIFOs with programmable read delay, readbacks and flow alarms.
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module lfs_fifo_sync (
  input  wire logic        hclk,        // Conversion clock, bus clock
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        hsel,        // AHB slave select
  input  wire logic [31:0] haddr,       // AHB address
  input  wire logic [1:0]  htrans,      // AHB transfer type
  input  wire logic        hwrite,      // AHB write
  input  wire logic [2:0]  hsize,       // AHB size, word only
  input  wire logic [31:0] hwdata,      // AHB write data
  input  wire logic        hready,      // AHB bus ready
  output logic             hreadyout,   // AHB slave ready
  output logic             hresp,       // AHB response, always OKAY
  output logic [31:0]      hrdata,      // AHB read data
  input  wire logic [3:0]  bank_tick,   // Bank clock edge, one per bank
  input  wire logic [47:0] bank_data,   // Bank words, bank b at 12*b
  input  wire logic [3:0]  bank_strobe, // Bank strobe, with tick
  input  wire logic        sysref,      // Alignment pulse or periodic
  output logic [47:0]      sample_out,  // Read-side samples per bank
  output logic             sample_valid,// Read side aligned
  output logic             osc_sync     // Oscillator sync pulse
);

  ////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [4:0] range_mask(input logic [1:0] md,
                                            input logic       dro);
    if (md == lfs_pkg::LVDS_MODE_FOUR) begin
      range_mask = lfs_pkg::MASK_32;
    end else if (md == lfs_pkg::LVDS_MODE_ONE && !dro) begin
      range_mask = lfs_pkg::MASK_8;
    end else if (md == lfs_pkg::LVDS_MODE_TWO && dro) begin
      range_mask = lfs_pkg::MASK_32;
    end else begin
      range_mask = lfs_pkg::MASK_16;
    end
  endfunction

  function automatic logic [4:0] wrap(input logic [4:0] v,
                                      input logic [4:0] m);
    wrap = v & m;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0]              ctrl_q;
  logic [4:0]               delay_q;
  logic [7:0]               alarm_q;
  logic [7:0]               alarm_set;
  logic                     wr_pend_q;
  logic [7:0]               wr_addr_q;
  logic [31:0]              rd_mux;
  logic [31:0]              hrdata_q;
  logic [4:0]               mask;
  logic [4:0]               osc_mod;
  logic [1:0]               lvds_mode;
  logic                     dro_en;
  logic                     align_src;
  logic                     sysref_en;
  logic [3:0]               bank_en;
  logic [11:0]              mem_q [lfs_pkg::NBANK][lfs_pkg::DEPTH];
  logic [4:0]               wr_ptr_q [lfs_pkg::NBANK];
  logic [4:0]               rb_q [lfs_pkg::NBANK];
  logic [11:0]              pre_q [lfs_pkg::NBANK];
  logic [11:0]              cap_q [lfs_pkg::NBANK];
  logic [4:0]               rd_cnt_q;
  logic [4:0]               rd_addr;
  logic [4:0]               prev_addr_q;
  logic [4:0]               osc_cnt_q;
  logic                     sysref_q;
  logic                     sysref_rise;
  logic                     ref_strobe;
  logic                     align_ev;
  logic                     cfg_wr;
  logic                     steady_q;
  logic                     osc_sync_q;
  logic                     valid_q;
  lfs_pkg::lfs_align_t      state_q;

  assign lvds_mode = ctrl_q[lfs_pkg::CTRL_MODE_LSB +: 2];
  assign dro_en    = ctrl_q[lfs_pkg::CTRL_DRO_BIT];
  assign align_src = ctrl_q[lfs_pkg::CTRL_ALIGN_BIT];
  assign sysref_en = ctrl_q[lfs_pkg::CTRL_SREN_BIT];
  assign bank_en   = ctrl_q[lfs_pkg::CTRL_BANK_LSB +: 4];
  assign mask      = range_mask(lvds_mode, dro_en);
  // Sync shift is the delay modulo 8, or 16 with double rate output
  assign osc_mod   = delay_q & (dro_en ? lfs_pkg::OSC_MOD16 : lfs_pkg::OSC_MOD8);

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign cfg_wr    = wr_pend_q && (wr_addr_q == lfs_pkg::OFF_CTRL ||
                                   wr_addr_q == lfs_pkg::OFF_DELAY);

  // Address phase captured; write data lands in the next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      unique case (haddr[7:0])
        lfs_pkg::OFF_CTRL:     rd_mux = ctrl_q;
        lfs_pkg::OFF_DELAY:    rd_mux = {27'h000_0000, delay_q};
        lfs_pkg::OFF_READBACK: begin
          for (int b = 0; b < lfs_pkg::NBANK; b++) begin
            rd_mux[b*lfs_pkg::RB_STRIDE +: 5] = rb_q[b];
          end
        end
        lfs_pkg::OFF_ALARM:    rd_mux = {24'h00_0000, alarm_q};
        lfs_pkg::OFF_STATUS:   rd_mux = {22'h00_0000, state_q, 3'h0, rd_cnt_q};
        default:               rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data is sampled at the address phase so it comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata_q <= rd_mux;
    end
  end

  // Control and delay registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= lfs_pkg::CTRL_RESET;
      delay_q <= lfs_pkg::DELAY_RESET;
    end else if (wr_pend_q && wr_addr_q == lfs_pkg::OFF_CTRL) begin
      ctrl_q  <= hwdata & 32'h0000_0f1f;
    end else if (wr_pend_q && wr_addr_q == lfs_pkg::OFF_DELAY) begin
      delay_q <= hwdata[4:0] & mask;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write side: each bank fills its own ring on its own clock tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int b = 0; b < lfs_pkg::NBANK; b++) begin
        wr_ptr_q[b] <= 5'h00;
      end
    end else begin
      for (int b = 0; b < lfs_pkg::NBANK; b++) begin
        if (bank_tick[b]) begin
          // Strobe word goes to slot 0, next word to slot 1
          if (bank_strobe[b]) begin
            wr_ptr_q[b] <= 5'h01;
          end else begin
            wr_ptr_q[b] <= wrap(wr_ptr_q[b] + 5'h01, mask);
          end
        end
      end
    end
  end

  // Storage has no reset; contents are don't-care until written
  always_ff @(posedge hclk) begin
    for (int b = 0; b < lfs_pkg::NBANK; b++) begin
      if (bank_tick[b]) begin
        mem_q[b][bank_strobe[b] ? 5'h00 : wr_ptr_q[b]] <=
          bank_data[b*lfs_pkg::WORD_W +: lfs_pkg::WORD_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Alignment: pulse edge or reference strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref;
    end
  end

  // A periodic pulse simply realigns to the same phase each period
  assign sysref_rise = sysref && !sysref_q && sysref_en;
  // Bank 0 is the strobe reference when enabled, otherwise bank 2
  assign ref_strobe  = bank_en[0] ? (bank_strobe[0] && bank_tick[0])
                                  : (bank_strobe[2] && bank_tick[2]);
  // Strobe alignment gives no deterministic latency across devices
  assign align_ev    = align_src ? ref_strobe : sysref_rise;

  ////////////////////////////////////////////////////////////////////
  // Read side pointer and oscillator sync sequencing
  assign rd_addr = wrap(rd_cnt_q - delay_q, mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt_q <= 5'h00;
    end else if (align_ev) begin
      rd_cnt_q <= 5'h00;
    end else if (state_q != lfs_pkg::LFS_ALIGN_IDLE) begin
      rd_cnt_q <= wrap(rd_cnt_q + 5'h01, mask);
    end
  end

  // The sync pulse trails the alignment by one cycle more than the delay modulo 8 or 16
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= lfs_pkg::LFS_ALIGN_IDLE;
      osc_cnt_q  <= 5'h00;
      osc_sync_q <= 1'b0;
    end else begin
      osc_sync_q <= 1'b0;
      if (align_ev) begin
        state_q   <= lfs_pkg::LFS_ALIGN_WAIT;
        osc_cnt_q <= osc_mod;
      end else begin
        unique case (state_q)
          lfs_pkg::LFS_ALIGN_IDLE: state_q <= lfs_pkg::LFS_ALIGN_IDLE;
          lfs_pkg::LFS_ALIGN_WAIT: begin
            if (osc_cnt_q == 5'h00) begin
              osc_sync_q <= 1'b1;
              state_q    <= lfs_pkg::LFS_ALIGN_RUN;
            end else begin
              osc_cnt_q  <= osc_cnt_q - 5'h01;
            end
          end
          lfs_pkg::LFS_ALIGN_RUN:  state_q <= lfs_pkg::LFS_ALIGN_RUN;
          default:                 state_q <= lfs_pkg::LFS_ALIGN_IDLE;
        endcase
      end
    end
  end

  assign osc_sync     = osc_sync_q;
  assign sample_valid = valid_q;

  ////////////////////////////////////////////////////////////////////
  // Readbacks: delay that would read each word as it arrives
  // Taken straight across from the write pointers, so banks with the
  // same clock ticks and strobes read back the same value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int b = 0; b < lfs_pkg::NBANK; b++) begin
        rb_q[b] <= 5'h00;
      end
    end else begin
      for (int b = 0; b < lfs_pkg::NBANK; b++) begin
        rb_q[b] <= wrap(rd_cnt_q - wr_ptr_q[b], mask);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Two capture flops per bank, early shadow and main, plus the slot
  // re-read one cycle later. A slot that changes just before or just
  // after its read shows a near violation. Only slow drift is seen:
  // a jump past the window reads clean, and constant data never trips.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int b = 0; b < lfs_pkg::NBANK; b++) begin
        pre_q[b] <= 12'h000;
        cap_q[b] <= 12'h000;
      end
      prev_addr_q <= 5'h00;
      steady_q    <= 1'b0;
      valid_q     <= 1'b0;
    end else begin
      for (int b = 0; b < lfs_pkg::NBANK; b++) begin
        pre_q[b] <= mem_q[b][wrap(rd_addr + 5'h01, mask)];
        cap_q[b] <= mem_q[b][rd_addr];
      end
      prev_addr_q <= rd_addr;
      // Compares are only meaningful after a plain pointer step
      steady_q    <= (state_q != lfs_pkg::LFS_ALIGN_IDLE) && !align_ev && !cfg_wr;
      valid_q     <= state_q != lfs_pkg::LFS_ALIGN_IDLE;
    end
  end

  always_comb begin
    for (int b = 0; b < lfs_pkg::NBANK; b++) begin
      sample_out[b*lfs_pkg::WORD_W +: lfs_pkg::WORD_W] = cap_q[b];
    end
  end

  // Unusable delay settings near the arrival point show up here
  always_comb begin
    alarm_set = 8'h00;
    for (int b = 0; b < lfs_pkg::NBANK; b++) begin
      alarm_set[lfs_pkg::ALM_UNDER_LSB + b] = steady_q && bank_en[b] &&
        (mem_q[b][rd_addr] != pre_q[b]);
      alarm_set[lfs_pkg::ALM_OVER_LSB + b]  = steady_q && bank_en[b] &&
        (mem_q[b][prev_addr_q] != cap_q[b]);
    end
  end

  // Sticky alarms, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_q <= 8'h00;
    end else if (wr_pend_q && wr_addr_q == lfs_pkg::OFF_ALARM) begin
      alarm_q <= (alarm_q & ~hwdata[7:0]) | alarm_set;
    end else begin
      alarm_q <= alarm_q | alarm_set;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions and covers
  logic [5:0] since_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_q <= 6'h3f;
    end else if (align_ev) begin
      since_q <= 6'h00;
    end else if (since_q != 6'h3f) begin
      since_q <= since_q + 6'h01;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  osc_delay_a: assert property (osc_sync |-> since_q == {1'b0, osc_mod} + 6'h01)
    else $error("oscillator sync not delayed by setting");
  // A mode change narrows the range one cycle before the pointer wraps
  rd_wrap_a: assert property (!$past(cfg_wr) |-> (rd_cnt_q & ~mask) == 5'h00)
    else $error("read pointer outside mode range");
  strobe_reset_a: assert property (bank_strobe[0] && bank_tick[0] |=> wr_ptr_q[0] == 5'h01)
    else $error("strobe did not reset write pointer");
  write_capture_a: assert property (bank_tick[1] && !bank_strobe[1]
      |=> mem_q[1][$past(wr_ptr_q[1])] == $past(bank_data[23:12]))
    else $error("bank word not captured");
  rb_range_a: assert property (!cfg_wr |=> (rb_q[2] & ~mask) == 5'h00)
    else $error("readback outside mode range");
  alarm_sticky_a: assert property (alarm_q[0] && !(wr_pend_q && hwdata[0]
      && wr_addr_q == lfs_pkg::OFF_ALARM) |=> alarm_q[0])
    else $error("alarm dropped without clear");
  alarm_cause_a: assert property ($rose(alarm_q[4]) |-> $past(steady_q))
    else $error("alarm raised without steady read");
  sysref_align_a: assert property (sysref && !sysref_q && sysref_en && !align_src
      |=> rd_cnt_q == 5'h00 && state_q == lfs_pkg::LFS_ALIGN_WAIT)
    else $error("alignment pulse not captured");
  ref_bank_a: assert property (align_src && !bank_en[0] && bank_strobe[2]
      && bank_tick[2] |=> rd_cnt_q == 5'h00)
    else $error("bank 2 strobe did not align read side");

  osc_fire_c:   cover property (osc_sync && osc_mod != 5'h00);
  under_c:      cover property ($rose(alarm_q[0]));
  over_c:       cover property ($rose(alarm_q[4]));
  strobe_al_c:  cover property (align_src && ref_strobe && state_q == lfs_pkg::LFS_ALIGN_RUN);

endmodule

// *** testbench/lfs_bank_src.sv ***
// Far-side logic model: ticks, words and strobes for the four input banks.
`timescale 1ns/1ps
module lfs_bank_src (
  input  wire logic        hclk,       // Conversion clock
  input  wire logic        hresetn,    // Reset, active low
  input  wire logic        toggle,     // Counting words, else constant
  input  wire logic [3:0]  stb_mask,   // Banks that send strobes
  output logic      [3:0]  bank_tick,  // One tick per bank each cycle
  output logic      [47:0] bank_data,  // Bank words
  output logic      [3:0]  bank_strobe // Strobe, with its tick
);
  logic [7:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  // All lanes of a bank move on its own tick; upper count bits make each
  // slot change every lap, else the flow alarms would never see data move
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q       <= 8'h00;
      bank_tick   <= 4'h0;
      bank_data   <= 48'h0;
      bank_strobe <= 4'h0;
    end else begin
      cnt_q       <= cnt_q + 8'h01;
      bank_tick   <= 4'hf;
      bank_data   <= {4{toggle ? {cnt_q, cnt_q[7:4]} : 12'h5a5}};
      bank_strobe <= (cnt_q[4:0] == 5'h00) ? stb_mask : 4'h0;
    end
  end
endmodule

// *** testbench/lfs_fifo_sync_tb.sv ***
// Self-checking bench for the bank input FIFO block.
`timescale 1ns/1ps
module lfs_fifo_sync_tb;
  logic        hclk, hresetn, hsel, hwrite, sysref, sref_q, toggle, ref_on;
  logic        hreadyout, hresp, sample_valid, osc_sync, osc_seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, ref_b;
  logic [2:0]  hsize;
  logic [3:0]  bank_tick, bank_strobe, stb_mask;
  logic [47:0] bank_data, sample_out;
  int          fails, n_compared, cyc, t_align, t_osc, rb0;
  logic [31:0] osc_ctl [5] = '{32'h0f12, 32'h0f16, 32'h0f12, 32'h0f12, 32'h0f16};
  logic [31:0] osc_dly [5] = '{32'hd, 32'hd, 32'h0, 32'h7, 32'h1f};
  int          osc_gap [5] = '{7, 15, 2, 9, 17};
  logic [31:0] rng_ctl [6] = '{32'h0f12, 32'h0f16, 32'h0f11, 32'h0f15, 32'h0f10, 32'h0f14};
  logic [4:0]  rng_msk [6] = '{5'h1f, 5'h1f, 5'h0f, 5'h1f, 5'h07, 5'h0f};
  localparam logic [31:0] A_CTRL = {24'h0, lfs_pkg::OFF_CTRL};
  localparam logic [31:0] A_DLY  = {24'h0, lfs_pkg::OFF_DELAY};
  localparam logic [31:0] A_RB   = {24'h0, lfs_pkg::OFF_READBACK};
  localparam logic [31:0] A_ALM  = {24'h0, lfs_pkg::OFF_ALARM};
  localparam logic [31:0] A_STAT = {24'h0, lfs_pkg::OFF_STATUS};

  lfs_fifo_sync dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bank_tick(bank_tick),
    .bank_data(bank_data), .bank_strobe(bank_strobe), .sysref(sysref),
    .sample_out(sample_out), .sample_valid(sample_valid), .osc_sync(osc_sync));
  lfs_bank_src src_u (
    .hclk(hclk), .hresetn(hresetn), .toggle(toggle), .stb_mask(stb_mask),
    .bank_tick(bank_tick), .bank_data(bank_data), .bank_strobe(bank_strobe));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz
  always #50 hclk = ~hclk;

  // Edge counter; pre-edge values are what the block samples at this edge
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (osc_sync === 1'b1 && !osc_seen) begin
      t_osc    <= cyc;
      osc_seen <= 1'b1;
    end
    if ((sysref && !sref_q) || (ref_on && bank_tick[ref_b] && bank_strobe[ref_b])) begin
      t_align  <= cyc;
      osc_seen <= 1'b0;
    end
    sref_q <= sysref;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check({47'h0, got}, {47'h0, exp});
  endtask

  task automatic print_verdict;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) fails++;
  endtask

  // One single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    check({16'h0, rd}, {16'h0, e});
  endtask

  // Waits for the first sync after the latest alignment, checks its distance
  task automatic wait_osc(input int g);
    int n;
    n = 0;
    repeat (4) @(posedge hclk);
    while (osc_seen !== 1'b1 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    check(48'(t_osc - t_align), 48'(g));
  endtask

  // Steps the delay over the arrival point; a slip here should alarm
  task automatic sweep;
    for (int k = -1; k < 2; k++) begin
      wr(A_DLY, 32'((rb0 + k) & 31));
      repeat (40) @(posedge hclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, well past the thousand or so cycles that the tests take
  initial begin
    repeat (30000) @(posedge hclk);
    fails++;
    print_verdict();
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; sysref = 0; sref_q = 0; toggle = 1; ref_on = 0;
    ref_b = 0; stb_mask = 4'hf; fails = 0; n_compared = 0; cyc = 0;
    t_align = 0; t_osc = 0; osc_seen = 0; rb0 = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_bit(sample_valid, 1'b0);
    check_bit(hresp, 1'b0);
    rdchk(A_CTRL, 32'h0000_0f12);
    rdchk(A_DLY, 32'h0);
    rdchk(A_ALM, 32'h0);
    rdchk(A_STAT, 32'h0);
    wr(32'h20, 32'hffff_ffff);
    rdchk(32'h20, 32'h0);
    wr(A_CTRL, 32'hffff_fffe);
    rdchk(A_CTRL, 32'h0000_0f1e);
    // Delay and readback ranges in every mode
    for (int i = 0; i < 6; i++) begin
      wr(A_CTRL, rng_ctl[i]);
      wr(A_DLY, 32'hff);
      rdchk(A_DLY, {27'h0, rng_msk[i]});
      ahb(1'b0, A_RB, 32'h0);
      check({16'h0, rd & ~{4{3'h0, rng_msk[i]}}}, 48'h0);
    end
    // Oscillator sync shift against the alignment pulse
    for (int i = 0; i < 5; i++) begin
      wr(A_CTRL, osc_ctl[i]);
      wr(A_DLY, osc_dly[i]);
      sysref <= 1'b1;
      repeat (3) @(posedge hclk);
      sysref <= 1'b0;
      wait_osc(osc_gap[i]);
      check_bit(sample_valid, 1'b1);
    end
    rdchk(A_CTRL, 32'h0000_0f16);
    ahb(1'b0, A_STAT, 32'h0);
    check({16'h0, rd & 32'h300}, 48'h300);
    // Readbacks of banks that share one clock relation
    wr(A_CTRL, 32'h0f12);
    wr(A_DLY, 32'h0);
    repeat (40) @(posedge hclk);
    ahb(1'b0, A_RB, 32'h0);
    rb0 = int'(rd[4:0]);
    for (int b = 1; b < 4; b++) begin
      check_bit(5'(rd[8*b+:5] - rd[4:0] + 5'h1) <= 5'h2, 1'b1);
    end
    sweep();
    ahb(1'b0, A_ALM, 32'h0);
    check_bit(rd[7:0] != 8'h00, 1'b1);
    wr(A_DLY, 32'((rb0 + 16) & 31));
    wr(A_ALM, 32'hff);
    repeat (40) @(posedge hclk);
    rdchk(A_ALM, 32'h0);
    // Constant words never alarm and pass through whole
    toggle <= 1'b0;
    repeat (40) @(posedge hclk);
    check(sample_out, {4{12'h5a5}});
    sweep();
    rdchk(A_ALM, 32'h0);
    toggle <= 1'b1;
    // Strobe alignment: bank 0 reference, then bank 2 when bank 0 is off
    wr(A_DLY, 32'h3);
    ref_on = 1'b1;
    wr(A_CTRL, 32'h0f1a);
    repeat (40) @(posedge hclk);
    wait_osc(5);
    ref_b = 2'd2;
    stb_mask <= 4'h4;
    wr(A_CTRL, 32'h0e1a);
    repeat (40) @(posedge hclk);
    wait_osc(5);
    stb_mask <= 4'h1;
    repeat (40) @(posedge hclk);
    osc_seen <= 1'b0;
    repeat (80) @(posedge hclk);
    check_bit(osc_seen, 1'b0);
    // Periodic pulse at the four-bank rate keeps realigning in phase
    ref_on = 1'b0;
    wr(A_CTRL, 32'h0f12);
    wr(A_DLY, 32'h5);
    repeat (3) begin
      sysref <= 1'b1;
      repeat (16) @(posedge hclk);
      sysref <= 1'b0;
      repeat (16) @(posedge hclk);
    end
    wait_osc(7);
    // Pulse enable and strobe alignment cleared first, so later pulses and strobes are ignored
    wr(A_CTRL, 32'h0f02);
    stb_mask <= 4'hf;
    sysref <= 1'b1;
    repeat (3) @(posedge hclk);
    sysref <= 1'b0;
    repeat (60) @(posedge hclk);
    check_bit(osc_seen, 1'b0);
    print_verdict();
  end
endmodule
